// [hw/hsf_device.sv]
// Function block: bus slave, SPI, I2C, flash store and standby hooks
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
module hsf_device (
    input wire logic clk_sys,
    input wire logic srst,
    hsf_if.dev bus,
    input wire logic por_ok,
    input wire logic spi_sclk_i,
    output logic spi_sclk_o,
    output logic spi_sclk_oe,
    input wire logic spi_mosi_i,
    output logic spi_mosi_o,
    output logic spi_mosi_oe,
    input wire logic spi_miso_i,
    output logic spi_miso_o,
    output logic spi_miso_oe,
    input wire logic spi_ss_n_i,
    output logic spi_cs_n,
    input wire logic i2c_scl_i,
    output logic i2c_scl_o,
    output logic i2c_scl_oe,
    input wire logic i2c_sda_i,
    output logic i2c_sda_o,
    output logic i2c_sda_oe,
    input wire logic stdby_pin,
    input wire logic jtag_stdby,
    input wire logic wake_pin,
    output logic cfg_wake,
    output logic cfg_stdby,
    output logic lp_bg_off,
    output logic lp_por_off,
    input wire logic ext_fl_rd,
    input wire logic [hsf_pkg::FL_AW-1:0] ext_fl_addr,
    output logic [hsf_pkg::DW-1:0] ext_fl_rdata
);
    import hsf_pkg::*;

    logic [1:0] por_s; // Power-good synchroniser
    logic rst; // Internal reset
    logic [NSYNC-1:0] sy1, sy2, sy3; // Pin synchronisers and history
    logic [7:0] spi_ctrl, i2c_ctrl, pwr_ctrl; // Control registers
    logic ack; // Bus acknowledge
    // SPI state
    logic sck_lvl, sp_busy, first, tx_full, rx_full, modf;
    logic [7:0] sp_cnt, tx_buf, tx_sh, rx_sh, rx_buf;
    logic [3:0] sp_hcnt;
    logic [2:0] sp_bit;
    // I2C state
    hsf_i2c_t i_st;
    logic [7:0] i_cnt, i_sh, i_rx;
    logic [3:0] i_bit;
    logic i_ph, i_done, i_nack, sl_act, sl_ack, stby_cmd;
    // Flash and power state
    logic [7:0] fmem [0:FL_BYTES-1]; // Store of 256 kbit
    logic [7:0] pbuf [0:PG_BYTES-1]; // Page assembly buffer
    logic [FL_AW-1:0] fl_addr;
    logic standby;

    // Supplies not good hold all but the pin synchronisers and flash memories in reset
    always_ff @(posedge clk_sys) begin
        if (srst) por_s <= 2'h0;
        else por_s <= {por_s[0], por_ok};
    end
    assign rst = srst | ~por_s[1];

    // Two flops on every pin; third stage only for edge finding
    always_ff @(posedge clk_sys) begin
        sy1 <= {wake_pin, jtag_stdby, stdby_pin, i2c_sda_i, i2c_scl_i,
                spi_ss_n_i, spi_miso_i, spi_mosi_i, spi_sclk_i};
        sy2 <= sy1;
        sy3 <= sy2;
    end

    // Bus decode; the slave answers one cycle after the strobe
    wire hit = bus.wb_cyc & bus.wb_stb & ~ack;
    wire wr = hit & bus.wb_we;
    wire rd = hit & ~bus.wb_we;
    wire [7:0] adr = bus.wb_adr;
    wire [7:0] wd = bus.wb_dat_m;

    // SPI controls
    wire spi_en = spi_ctrl[SC_EN];
    wire mstr = spi_ctrl[SC_MSTR];
    wire cpol = spi_ctrl[SC_CPOL];
    wire cpha = spi_ctrl[SC_CPHA];
    wire lsbf = spi_ctrl[SC_LSBF];
    wire sel = spi_en & ~mstr & ~sy2[Y_SS];
    wire sel_rise = sel & sy3[Y_SS];
    wire sl_lvl = sy2[Y_SCK] ^ cpol;
    wire sl_prv = sy3[Y_SCK] ^ cpol;
    wire tick = sp_busy & (sp_cnt == 8'(SPI_HALF_CYC - 1));
    wire lead = mstr ? tick & ~sck_lvl : sel & sl_lvl & ~sl_prv;
    wire trail = mstr ? tick & sck_lvl : sel & ~sl_lvl & sl_prv;
    wire samp_e = cpha ? trail : lead;
    wire shft_e = (cpha ? lead : trail) & ~first;
    wire in_bit = mstr ? sy2[Y_MISO] : sy2[Y_MOSI];
    wire out_bit = lsbf ? tx_sh[0] : tx_sh[SPI_BITS-1];
    wire [7:0] rx_nx = lsbf ? {in_bit, rx_sh[7:1]} : {rx_sh[6:0], in_bit};
    wire byte_dn = samp_e & (sp_bit == 3'(SPI_BITS - 1));
    // Another master pulling our select low is a conflict
    wire modf_ev = spi_en & mstr & ~sy2[Y_SS];
    wire start_m = spi_en & mstr & ~sp_busy & tx_full & ~modf_ev;
    wire load_s = ~mstr & (sel_rise | (byte_dn & sel));
    wire load = start_m | load_s;

    // Register writes; a mode fault overrides a master write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            spi_ctrl <= CTRL_RST;
            i2c_ctrl <= CTRL_RST;
            pwr_ctrl <= CTRL_RST;
        end else begin
            if (wr && adr == A_SPI_CTRL) spi_ctrl <= wd;
            if (wr && adr == A_I2C_CTRL) i2c_ctrl <= wd;
            if (wr && adr == A_PWR) pwr_ctrl <= wd;
            if (modf_ev) spi_ctrl[SC_MSTR] <= 1'b0;
        end
    end

    // Master clock generator: sixteen half periods per word
    always_ff @(posedge clk_sys) begin
        if (rst || modf_ev) begin
            sp_busy <= 1'b0;
            sp_cnt <= 8'h00;
            sp_hcnt <= 4'h0;
            sck_lvl <= 1'b0;
        end else if (start_m) begin
            sp_busy <= 1'b1;
            sp_cnt <= 8'h00;
            sp_hcnt <= 4'h0;
        end else if (tick) begin
            sp_cnt <= 8'h00;
            sck_lvl <= ~sck_lvl;
            sp_hcnt <= sp_hcnt + 1'b1;
            if (sp_hcnt == 4'(SPI_HALVES - 1)) sp_busy <= 1'b0;
        end else if (sp_busy) begin
            sp_cnt <= sp_cnt + 1'b1;
        end
    end

    // Shift engine: out and in on the same clock pair
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_sh <= 8'h00;
            rx_sh <= 8'h00;
            sp_bit <= 3'h0;
            first <= 1'b1;
        end else begin
            if (samp_e) rx_sh <= rx_nx;
            if (samp_e) sp_bit <= sp_bit + 1'b1;
            if (lead) first <= 1'b0;
            // Phase 1 holds the first bit over the first edge
            if (shft_e) tx_sh <= lsbf ? tx_sh >> 1 : tx_sh << 1;
            if (load) begin
                tx_sh <= tx_full ? tx_buf : 8'hFF;
                sp_bit <= 3'h0;
                first <= 1'b1;
            end
        end
    end

    // Holding buffers let software work while a word shifts
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_buf <= 8'h00;
            tx_full <= 1'b0;
            rx_buf <= 8'h00;
            rx_full <= 1'b0;
            modf <= 1'b0;
        end else begin
            if (load) tx_full <= 1'b0;
            if (wr && adr == A_SPI_DATA) begin
                tx_buf <= wd;
                tx_full <= 1'b1;
            end
            if (rd && adr == A_SPI_DATA) rx_full <= 1'b0;
            if (byte_dn) begin
                rx_buf <= rx_nx;
                rx_full <= 1'b1;
            end
            // Set wins over the write-one clear
            if (wr && adr == A_SPI_STAT && wd[SS_MODF]) modf <= 1'b0;
            if (modf_ev) modf <= 1'b1;
        end
    end

    // SPI pins; a faulted master has already let go
    assign spi_sclk_o = sck_lvl ^ cpol;
    assign spi_sclk_oe = spi_en & mstr;
    assign spi_mosi_o = out_bit;
    assign spi_mosi_oe = spi_en & mstr;
    assign spi_miso_o = out_bit;
    assign spi_miso_oe = sel;
    assign spi_cs_n = ~sp_busy;
    assign bus.spi_irq = modf & spi_ctrl[SC_MFIE];

    // I2C controls and conditions seen on the pins
    wire i_en = i2c_ctrl[IC_EN];
    wire i_ms = i2c_ctrl[IC_MSTR];
    wire i_rcv = i2c_ctrl[IC_RCV];
    wire i_tk = (i_st != I_IDLE) & (i_cnt == 8'(I2C_HALF_CYC - 1));
    wire i_ack = i_bit == 4'(I2C_ACK_BIT);
    wire scl_r = sy2[Y_SCL] & ~sy3[Y_SCL];
    wire scl_f = ~sy2[Y_SCL] & sy3[Y_SCL];
    wire st_c = sy2[Y_SCL] & sy3[Y_SDA] & ~sy2[Y_SDA];
    wire sp_c = sy2[Y_SCL] & ~sy3[Y_SDA] & sy2[Y_SDA];
    wire [7:0] sl_nx = {i_sh[6:0], sy2[Y_SDA]};
    wire scl_low = ((i_st == I_BIT) | (i_st == I_STOP)) & ~i_ph;
    // Ack slot: pull low only when we are the receiver
    wire m_bit = i_ack ? i_rcv : (i_rcv ? 1'b0 : ~i_sh[7]);
    wire m_drv = (i_st == I_START) | (i_st == I_STOP) |
                 ((i_st == I_BIT) & m_bit);

    // Master sequencer plus slave receiver sharing one shifter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            i_st <= I_IDLE;
            i_cnt <= 8'h00;
            i_ph <= 1'b0;
            i_bit <= 4'h0;
            i_sh <= 8'h00;
            i_rx <= 8'h00;
            i_done <= 1'b0;
            i_nack <= 1'b0;
            sl_act <= 1'b0;
            sl_ack <= 1'b0;
            stby_cmd <= 1'b0;
        end else begin
            stby_cmd <= 1'b0;
            i_cnt <= i_tk || i_st == I_IDLE ? 8'h00 : i_cnt + 1'b1;
            if (wr && adr == A_I2C_STAT) begin
                if (wd[IS_DONE]) i_done <= 1'b0;
                if (wd[IS_NACK]) i_nack <= 1'b0;
            end
            case (i_st)
                I_IDLE: begin
                    if (wr && adr == A_I2C_DATA && i_en && i_ms) begin
                        i_sh <= wd;
                        i_st <= I_START;
                    end
                end
                I_START: begin
                    if (i_tk) begin
                        i_st <= I_BIT;
                        i_ph <= 1'b0;
                        i_bit <= 4'h0;
                    end
                end
                I_BIT: begin
                    if (i_tk) begin
                        i_ph <= ~i_ph;
                        if (i_ph) begin
                            i_bit <= i_bit + 1'b1;
                            if (!i_ack) i_sh <= sl_nx;
                            if (i_ack) i_nack <= sy2[Y_SDA];
                            if (i_ack) i_st <= I_STOP;
                        end
                    end
                end
                I_STOP: begin
                    if (i_tk) begin
                        i_ph <= ~i_ph;
                        if (i_ph) begin
                            i_st <= I_IDLE;
                            i_rx <= i_sh;
                            i_done <= 1'b1;
                        end
                    end
                end
                default: i_st <= I_IDLE;
            endcase
            // Slave follows the far master's clock
            if (!i_en || i_ms || sp_c) begin
                sl_act <= 1'b0;
                sl_ack <= 1'b0;
            end else if (st_c) begin
                sl_act <= 1'b1;
                i_bit <= 4'h0;
            end else if (sl_act && scl_r && !i_ack) begin
                i_sh <= sl_nx;
                i_bit <= i_bit + 1'b1;
                if (i_bit == 4'(I2C_ACK_BIT - 1)) begin
                    i_rx <= sl_nx;
                    i_done <= 1'b1;
                    stby_cmd <= sl_nx == I2C_STBY_CMD;
                end
            end else if (sl_act && scl_f && i_ack) begin
                if (sl_ack) i_bit <= 4'h0;
                sl_ack <= ~sl_ack;
            end
        end
    end

    // Open-drain pins: only a low is ever driven
    assign i2c_scl_o = 1'b0;
    assign i2c_scl_oe = i_en & i_ms & scl_low;
    assign i2c_sda_o = 1'b0;
    assign i2c_sda_oe = i_en & (i_ms ? m_drv : sl_ack);
    assign bus.i2c_irq = i2c_ctrl[IC_IEN] & i_done;

    // Standby entry and wake; clocks and logic keep running
    wire stby_ev = (sy2[Y_STBY] ^ sy3[Y_STBY]) | stby_cmd |
                   (sy2[Y_JTAG] & ~sy3[Y_JTAG]);
    wire wake_ev = sy2[Y_WAKE] & ~sy3[Y_WAKE];
    wire wake_en = i2c_ctrl[IC_WAKE];
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            standby <= 1'b0;
            cfg_wake <= 1'b0;
            cfg_stdby <= 1'b0;
            lp_bg_off <= 1'b0;
            lp_por_off <= 1'b0;
        end else begin
            if (stby_ev) standby <= 1'b1;
            else if (wake_ev) standby <= 1'b0;
            cfg_stdby <= wake_en & standby;
            cfg_wake <= wake_en & standby & wake_ev;
            lp_bg_off <= standby & pwr_ctrl[PC_BG];
            lp_por_off <= standby & pwr_ctrl[PC_POR];
        end
    end

    // Flash store: whole pages programmed from the page buffer
    wire fl_wd = wr && adr == A_FL_DATA;
    wire fl_rd = rd && adr == A_FL_DATA;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fl_addr <= '0;
        end else begin
            if (wr && adr == A_FL_ADRL) fl_addr[7:0] <= wd;
            if (wr && adr == A_FL_ADRH) fl_addr[FL_AW-1:8] <= wd[6:0];
            if (fl_wd || fl_rd) fl_addr <= fl_addr + 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (fl_wd) pbuf[fl_addr[PG_AW-1:0]] <= wd;
        if (wr && adr == A_FL_PROG) begin
            for (int i = 0; i < PG_BYTES; i++) begin
                fmem[{fl_addr[FL_AW-1:PG_AW], PG_AW'(i)}] <= pbuf[i];
            end
        end
        if (ext_fl_rd) ext_fl_rdata <= fmem[ext_fl_addr];
    end

    // Read selection and registered answer
    wire [7:0] spi_st = {4'h0, modf, mstr ? sp_busy : sel, rx_full, tx_full};
    wire [7:0] i2c_st = {5'h00, i_st != I_IDLE || sl_act, i_nack, i_done};
    wire [7:0] rmux =
        adr == A_SPI_CTRL ? spi_ctrl :
        adr == A_SPI_DATA ? rx_buf :
        adr == A_SPI_STAT ? spi_st :
        adr == A_I2C_CTRL ? i2c_ctrl :
        adr == A_I2C_DATA ? i_rx :
        adr == A_I2C_STAT ? i2c_st :
        adr == A_FL_ADRL ? fl_addr[7:0] :
        adr == A_FL_ADRH ? {1'b0, fl_addr[FL_AW-1:8]} :
        adr == A_FL_DATA ? fmem[fl_addr] :
        adr == A_PWR ? {pwr_ctrl[7:3], standby, pwr_ctrl[1:0]} :
        8'h00;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack <= 1'b0;
            bus.wb_dat_s <= 8'h00;
        end else begin
            ack <= hit;
            if (rd) bus.wb_dat_s <= rmux;
        end
    end
    assign bus.wb_ack = ack;
endmodule

// [hw/hsf_host.sv]
// Bus master end: software port turned into single bus cycles
`timescale 1ns/100ps
module hsf_host (
    input wire logic clk_sys,
    input wire logic srst,
    hsf_if.host bus,
    input wire logic [3:0] sw_addr,
    input wire logic [7:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [7:0] sw_rdata
);
    import hsf_pkg::*;

    localparam logic [3:0] H_ADDR = 4'h0; // Target offset
    localparam logic [3:0] H_WDATA = 4'h1; // Write byte
    localparam logic [3:0] H_GO = 4'h2; // Bit 0: 1 write, 0 read
    localparam logic [3:0] H_STAT = 4'h3; // Busy, done, interrupts
    localparam logic [3:0] H_RDATA = 4'h4; // Byte read back

    logic [7:0] h_addr, h_wdata, h_rdata; // Command registers
    logic busy, done; // Cycle in flight, finished

    // A go while busy is ignored; one cycle at a time
    wire go = sw_wr && sw_addr == H_GO && !busy;
    wire fin = busy & bus.wb_ack;

    // Command registers and bus cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            h_addr <= 8'h00;
            h_wdata <= 8'h00;
            h_rdata <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            bus.wb_cyc <= 1'b0;
            bus.wb_stb <= 1'b0;
            bus.wb_we <= 1'b0;
            bus.wb_adr <= 8'h00;
            bus.wb_dat_m <= 8'h00;
        end else begin
            if (sw_wr && sw_addr == H_ADDR) h_addr <= sw_wdata;
            if (sw_wr && sw_addr == H_WDATA) h_wdata <= sw_wdata;
            if (go) begin
                busy <= 1'b1;
                done <= 1'b0;
                bus.wb_cyc <= 1'b1;
                bus.wb_stb <= 1'b1;
                bus.wb_we <= sw_wdata[0];
                bus.wb_adr <= h_addr;
                bus.wb_dat_m <= h_wdata;
            end else if (fin) begin
                busy <= 1'b0;
                done <= 1'b1;
                bus.wb_cyc <= 1'b0;
                bus.wb_stb <= 1'b0;
                if (!bus.wb_we) h_rdata <= bus.wb_dat_s;
            end
        end
    end

    // Software read port, data one cycle after the strobe
    wire [7:0] stat = {4'h0, bus.spi_irq, bus.i2c_irq, done, busy};
    wire [7:0] rsel = sw_addr == H_ADDR ? h_addr :
                      sw_addr == H_WDATA ? h_wdata :
                      sw_addr == H_STAT ? stat :
                      sw_addr == H_RDATA ? h_rdata : 8'h00;
    always_ff @(posedge clk_sys) begin
        if (srst) sw_rdata <= 8'h00;
        else if (sw_rd) sw_rdata <= rsel;
    end
endmodule

// [hw/hsf_if.sv]
// Eight-bit bus and request lines joining master and function block
`timescale 1ns/100ps
interface hsf_if;
    logic wb_cyc;
    logic wb_stb;
    logic wb_we;
    logic wb_ack;
    logic [7:0] wb_adr;
    logic [7:0] wb_dat_m;
    logic [7:0] wb_dat_s;
    logic i2c_irq;
    logic spi_irq;
    // Function block end
    modport dev (
        input wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_m,
        output wb_ack, wb_dat_s, i2c_irq, spi_irq
    );
    // Bus master end
    modport host (
        output wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_m,
        input wb_ack, wb_dat_s, i2c_irq, spi_irq
    );
endinterface

// [hw/hsf_pkg.sv]
// Shared constants for the serial and flash function block
package hsf_pkg;
    // Bus widths
    localparam int DW = 8;
    localparam int AW = 8;
    // Device register offsets
    localparam logic [7:0] A_SPI_CTRL = 8'h00;
    localparam logic [7:0] A_SPI_DATA = 8'h01;
    localparam logic [7:0] A_SPI_STAT = 8'h02;
    localparam logic [7:0] A_I2C_CTRL = 8'h03;
    localparam logic [7:0] A_I2C_DATA = 8'h04;
    localparam logic [7:0] A_I2C_STAT = 8'h05;
    localparam logic [7:0] A_FL_ADRL = 8'h06;
    localparam logic [7:0] A_FL_ADRH = 8'h07;
    localparam logic [7:0] A_FL_DATA = 8'h08;
    localparam logic [7:0] A_FL_PROG = 8'h09;
    localparam logic [7:0] A_PWR = 8'h0A;
    // SPI control and status bits
    localparam int SC_EN = 0, SC_MSTR = 1, SC_CPOL = 2;
    localparam int SC_CPHA = 3, SC_LSBF = 4, SC_MFIE = 5;
    localparam int SS_TXF = 0, SS_RXF = 1, SS_BUSY = 2, SS_MODF = 3;
    // I2C control and status bits
    localparam int IC_EN = 0, IC_MSTR = 1, IC_IEN = 2;
    localparam int IC_RCV = 3, IC_WAKE = 4;
    localparam int IS_DONE = 0, IS_NACK = 1, IS_BUSY = 2;
    // Power control bits
    localparam int PC_BG = 0, PC_POR = 1, PC_STBY = 2;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Timing
    localparam int CLK_NS = 25;
    localparam int SPI_HALF_NS = 100;
    localparam int I2C_HALF_NS = 5000;
    localparam int SPI_HALF_CYC = (SPI_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int I2C_HALF_CYC = (I2C_HALF_NS + CLK_NS - 1) / CLK_NS;
    // Word and frame sizes
    localparam int SPI_BITS = 8;
    localparam int SPI_HALVES = 2 * SPI_BITS;
    localparam int I2C_ACK_BIT = 8;
    // Flash store: 256 kbit in 16-byte pages
    localparam int FL_BYTES = 32768;
    localparam int FL_AW = 15;
    localparam int PG_BYTES = 16;
    localparam int PG_AW = 4;
    // I2C slave byte that asks for standby
    localparam logic [7:0] I2C_STBY_CMD = 8'hA5;
    // Synchroniser lanes
    localparam int Y_SCK = 0, Y_MOSI = 1, Y_MISO = 2, Y_SS = 3, Y_SCL = 4;
    localparam int Y_SDA = 5, Y_STBY = 6, Y_JTAG = 7, Y_WAKE = 8, NSYNC = 9;
    // I2C master sequencer states
    typedef enum logic [1:0] {I_IDLE, I_START, I_BIT, I_STOP} hsf_i2c_t;
endpackage

// [sim/hsf_bus_sva.sv]
// Protocol checker for the byte bus between the two ends
`timescale 1ns/100ps
module hsf_bus_sva (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic wb_ack,
    input wire logic [7:0] wb_adr,
    input wire logic [7:0] wb_dat_m
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Fresh request, not yet answered
    wire req = wb_cyc & wb_stb & ~wb_ack;
    property p_ack_next;
        req |=> wb_ack;
    endproperty
    property p_ack_cause;
        wb_ack |-> $past(req);
    endproperty
    property p_ack_pulse;
        wb_ack |=> !wb_ack;
    endproperty
    property p_stb_drop;
        wb_ack |=> !wb_stb;
    endproperty
    property p_stb_cyc;
        wb_stb |-> wb_cyc;
    endproperty
    property p_idle;
        !(wb_cyc && wb_stb) |=> !wb_ack;
    endproperty
    // Address and direction held until answered
    property p_adr_hold;
        req |=> $stable(wb_adr) && $stable(wb_we);
    endproperty
    property p_dat_hold;
        req && wb_we |=> $stable(wb_dat_m);
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack");
    a_ack_cause: assert property (p_ack_cause) else $error("ack");
    a_ack_pulse: assert property (p_ack_pulse) else $error("long");
    a_stb_drop: assert property (p_stb_drop) else $error("stb");
    a_stb_cyc: assert property (p_stb_cyc) else $error("cyc");
    a_idle: assert property (p_idle) else $error("idle ack");
    a_adr_hold: assert property (p_adr_hold) else $error("adr");
    a_dat_hold: assert property (p_dat_hold) else $error("dat");
    // Main traffic kinds
    c_write: cover property (req && wb_we);
    c_read: cover property (req && !wb_we);
    c_b2b: cover property (wb_ack ##[2:12] wb_ack);
endmodule

// [sim/hsf_hardened_serial_flash_functions_tb.sv]
// Bench joining host and function block through the software port
`timescale 1ns/100ps
module hsf_hardened_serial_flash_functions_tb;
    import hsf_pkg::*;
    logic clk_sys = 0, srst = 1, por_ok = 0;
    logic [3:0] sw_addr = 0;
    logic [7:0] sw_wdata = 0, pg_d[16];
    logic sw_wr = 0, sw_rd = 0, rd_q = 0, fl_q = 0, ext_fl_rd = 0;
    logic stdby_pin = 0, jtag_stdby = 0, wake_pin = 0, spi_ss_n_i = 1;
    logic [14:0] ext_fl_addr = 0, fa;
    logic [31:0] seed = 32'hb424_c27e;
    logic [15:0] exp_q[$]; // Mask in high byte, value in low
    int miscompares = 0, tests_run = 0, k;
    wire [7:0] sw_rdata, ext_fl_rdata;
    wire spi_sclk_o, spi_sclk_oe, spi_mosi_o, spi_mosi_oe, spi_miso_o;
    wire spi_miso_oe, spi_cs_n, i2c_scl_o, i2c_scl_oe, i2c_sda_o;
    wire i2c_sda_oe, cfg_wake, cfg_stdby, lp_bg_off, lp_por_off;
    // SPI lines looped back; I2C lines pulled up
    wire spi_sclk_i = spi_sclk_o;
    wire spi_mosi_i = spi_mosi_o;
    wire spi_miso_i = spi_mosi_o;
    wire i2c_scl_i = ~i2c_scl_oe;
    wire i2c_sda_i = ~i2c_sda_oe;
    hsf_if bus();
    hsf_host i_hsf_host (.clk_sys, .srst, .bus(bus), .sw_addr, .sw_wdata,
        .sw_wr, .sw_rd, .sw_rdata);
    hsf_device i_hsf_device (.clk_sys, .srst, .bus(bus), .por_ok,
        .spi_sclk_i, .spi_sclk_o, .spi_sclk_oe, .spi_mosi_i, .spi_mosi_o,
        .spi_mosi_oe, .spi_miso_i, .spi_miso_o, .spi_miso_oe, .spi_ss_n_i,
        .spi_cs_n, .i2c_scl_i, .i2c_scl_o, .i2c_scl_oe, .i2c_sda_i,
        .i2c_sda_o, .i2c_sda_oe, .stdby_pin, .jtag_stdby, .wake_pin,
        .cfg_wake, .cfg_stdby, .lp_bg_off, .lp_por_off, .ext_fl_rd,
        .ext_fl_addr, .ext_fl_rdata);
    hsf_bus_sva i_hsf_bus_sva (.clk_sys, .srst, .wb_cyc(bus.wb_cyc),
        .wb_stb(bus.wb_stb), .wb_we(bus.wb_we), .wb_ack(bus.wb_ack),
        .wb_adr(bus.wb_adr), .wb_dat_m(bus.wb_dat_m));
    initial forever #12.5 clk_sys = ~clk_sys;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Masked byte compare against oldest note
    task automatic cmp(input logic [7:0] got);
        logic [15:0] n;
        n = exp_q.pop_front();
        tests_run++;
        if ((got & n[15:8]) !== n[7:0]) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, n[7:0]);
        end
    endtask
    // Pin level compare
    task automatic pin(input logic got, input logic e);
        tests_run++;
        if (got !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, e);
        end
    endtask
    // One software strobe, gap after so strobes never merge
    task automatic sw(input logic w, input logic [3:0] a, input logic [7:0] v);
        sw_wr <= w;
        sw_rd <= ~w;
        sw_addr <= a;
        sw_wdata <= v;
        @(posedge clk_sys);
        sw_wr <= 0;
        sw_rd <= 0;
        @(posedge clk_sys);
    endtask
    // One bus cycle via the host; done lands by the third cycle
    task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] v);
        sw(1, 4'h0, a);
        sw(1, 4'h1, v);
        sw(1, 4'h2, {7'h00, w});
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, m);
        dev(0, a, 8'h00);
        exp_q.push_back({m, e});
        sw(0, 4'h4, 8'h00);
    endtask
    task automatic set_fa();
        dev(1, A_FL_ADRL, fa[7:0]);
        dev(1, A_FL_ADRH, {1'b0, fa[14:8]});
    endtask
    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Result watcher: read data stands one cycle after its strobe
    always @(posedge clk_sys) begin
        if (rd_q) cmp(sw_rdata);
        if (fl_q) cmp(ext_fl_rdata);
        rd_q <= sw_rd;
        fl_q <= ext_fl_rd;
    end
    initial begin
        por_ok <= 1;
        repeat (2) @(posedge clk_sys);
        srst <= 0;
        repeat (4) @(posedge clk_sys);
        // Random page: fill, program, read back both ways
        seed = lfsr(seed);
        fa = {seed[10:0], 4'h0};
        set_fa();
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            pg_d[i] = seed[7:0];
            dev(1, A_FL_DATA, pg_d[i]);
        end
        set_fa();
        dev(1, A_FL_PROG, 8'h00);
        set_fa();
        for (int i = 0; i < 16; i++) rd(A_FL_DATA, pg_d[i], 8'hFF);
        for (int i = 0; i < 16; i += 5) begin
            exp_q.push_back({8'hFF, pg_d[i]});
            ext_fl_rd <= 1;
            ext_fl_addr <= fa + 15'(i);
            @(posedge clk_sys);
            ext_fl_rd <= 0;
            @(posedge clk_sys);
        end
        // Every clock mode and bit order, two words queued
        for (int m = 0; m < 8; m++) begin
            seed = lfsr(seed);
            dev(1, A_SPI_CTRL, {3'h0, 3'(m), 2'h3});
            dev(1, A_SPI_DATA, seed[7:0]);
            dev(1, A_SPI_DATA, seed[15:8]);
            // First word needs 60 shift cycles, or all 64 with phase 1, before it lands
            repeat (60) @(posedge clk_sys);
            rd(A_SPI_DATA, seed[7:0], 8'hFF);
            repeat (80) @(posedge clk_sys);
            rd(A_SPI_DATA, seed[15:8], 8'hFF);
        end
        // Select driven low while master
        dev(1, A_SPI_CTRL, 8'h23);
        spi_ss_n_i <= 0;
        repeat (8) @(posedge clk_sys);
        pin(spi_sclk_oe, 0);
        rd(A_SPI_STAT, 8'h08, 8'h08);
        exp_q.push_back(16'h0808);
        sw(0, 4'h3, 8'h00);
        spi_ss_n_i <= 1;
        dev(1, A_SPI_STAT, 8'h08);
        rd(A_SPI_STAT, 8'h00, 8'h08);
        // Master byte on pulled-up lines: own bits loop back, nack
        seed = lfsr(seed);
        dev(1, A_I2C_CTRL, 8'h07);
        dev(1, A_I2C_DATA, seed[7:0]);
        k = 0;
        while (bus.i2c_irq !== 1'b1 && k < 6000) begin
            @(posedge clk_sys);
            k++;
        end
        pin(k < 6000, 1);
        rd(A_I2C_STAT, 8'h03, 8'h07);
        rd(A_I2C_DATA, seed[7:0], 8'hFF);
        // Standby by pin toggle with wake enabled
        dev(1, A_I2C_CTRL, 8'h10);
        dev(1, A_PWR, 8'h01);
        stdby_pin <= 1;
        repeat (8) @(posedge clk_sys);
        pin(cfg_stdby, 1);
        pin(lp_bg_off, 1);
        pin(lp_por_off, 0);
        rd(A_PWR, 8'h04, 8'h04);
        wake_pin <= 1;
        k = 0;
        while (cfg_wake !== 1'b1 && k < 10) begin
            @(posedge clk_sys);
            k++;
        end
        pin(k < 10, 1);
        // Wake disabled: cfg outputs stay low, state still entered
        dev(1, A_I2C_CTRL, 8'h00);
        jtag_stdby <= 1;
        repeat (8) @(posedge clk_sys);
        pin(cfg_stdby, 0);
        rd(A_PWR, 8'h04, 8'h04);
        finish_test();
    end
endmodule
